// [rtl/cif_top.sv]
// Purpose: Interrupt control unit and core status flags of an 8-bit core
// Assumes: Core supplies phase_two_pulse, stack status and decoded instruction events
// Notes: Acknowledge is a one-cycle pulse issued on a phase-two pulse
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module cif_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_irq_n,
  input wire logic timer_overflow,
  input wire logic conv_done,
  input wire logic phase_two_pulse,
  input wire cif_pkg::cif_core_evt_s core_evt,
  input wire cif_pkg::cif_alu_req_s alu_req,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [7:0] irq_control_reg,
  output logic [7:0] core_flags,
  output logic irq_ack,
  output logic [10:0] irq_vector,
  output logic push_pc,
  output logic wake_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and request qualification
  logic ext_pin_q;
  logic ext_fall;
  logic wr_flags;
  logic wr_ctrl;
  logic global_irq_enable;
  logic ext_irq_enable;
  logic timer_irq_enable;
  logic conv_irq_enable;
  logic ext_irq_pending;
  logic timer_irq_pending;
  logic conv_irq_pending;
  logic ext_ready;
  logic tmr_ready;
  logic conv_ready;
  logic any_ready;
  logic take_ext;
  logic take_tmr;
  logic take_conv;
  logic do_ack;
  logic [10:0] next_vector;
  logic [7:0] next_ctrl;
  logic [7:0] ctrl_after_wr;
  logic [7:0] next_core;
  logic [3:0] alu_next;
  logic alu_update;
  logic [7:0] next_rdata;
  logic [2:0] src_event;
  cif_pkg::cif_state_e state;
  cif_pkg::cif_state_e next_state;

  assign global_irq_enable = irq_control_reg[cif_pkg::IC_GLOBAL_EN];
  assign ext_irq_enable = irq_control_reg[cif_pkg::IC_EXT_EN];
  assign timer_irq_enable = irq_control_reg[cif_pkg::IC_TMR_EN];
  assign conv_irq_enable = irq_control_reg[cif_pkg::IC_CONV_EN];
  assign ext_irq_pending = irq_control_reg[cif_pkg::IC_EXT_PEND];
  assign timer_irq_pending = irq_control_reg[cif_pkg::IC_TMR_PEND];
  assign conv_irq_pending = irq_control_reg[cif_pkg::IC_CONV_PEND];

  assign wr_flags = reg_wr && (reg_addr == cif_pkg::ADDR_CORE_FLAGS);
  assign wr_ctrl = reg_wr && (reg_addr == cif_pkg::ADDR_IRQ_CTRL);
  assign ext_fall = ext_pin_q && !ext_irq_n;

  // Source events are taken independently of enables
  assign src_event = {conv_done, timer_overflow, ext_fall};

  // Both own and global enable must be one
  assign ext_ready = global_irq_enable && ext_irq_enable && ext_irq_pending;
  assign tmr_ready = global_irq_enable && timer_irq_enable && timer_irq_pending;
  assign conv_ready = global_irq_enable && conv_irq_enable && conv_irq_pending;
  assign any_ready = ext_ready || tmr_ready || conv_ready;

  // Full stack holds the request pending
  assign do_ack = (state == cif_pkg::CIF_ST_IDLE) && phase_two_pulse && any_ready
                  && !core_evt.stack_full;
  assign take_ext = do_ack && ext_ready;
  assign take_tmr = do_ack && !ext_ready && tmr_ready;
  assign take_conv = do_ack && !ext_ready && !tmr_ready && conv_ready;
  assign next_vector = take_ext ? cif_pkg::VEC_EXT :
                       take_tmr ? cif_pkg::VEC_TMR : cif_pkg::VEC_CONV;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt control register update
  assign ctrl_after_wr = wr_ctrl ? (reg_wdata & cif_pkg::IRQ_CTRL_WMASK) : irq_control_reg;

  always_comb begin
    next_ctrl = ctrl_after_wr;
    // Return-and-enable restores the global enable
    if (core_evt.return_and_enable) begin
      next_ctrl[cif_pkg::IC_GLOBAL_EN] = 1'b1;
    end
    if (do_ack) begin
      next_ctrl[cif_pkg::IC_GLOBAL_EN] = 1'b0;
    end
    if (take_ext) begin
      next_ctrl[cif_pkg::IC_EXT_PEND] = 1'b0;
    end
    if (take_tmr) begin
      next_ctrl[cif_pkg::IC_TMR_PEND] = 1'b0;
    end
    if (take_conv) begin
      next_ctrl[cif_pkg::IC_CONV_PEND] = 1'b0;
    end
    // New source events win over software or acknowledge clears
    if (src_event[0]) begin
      next_ctrl[cif_pkg::IC_EXT_PEND] = 1'b1;
    end
    if (src_event[1]) begin
      next_ctrl[cif_pkg::IC_TMR_PEND] = 1'b1;
    end
    if (src_event[2]) begin
      next_ctrl[cif_pkg::IC_CONV_PEND] = 1'b1;
    end
    next_ctrl[7] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core flags
  cif_alu_flags u_alu_flags (
    .req(alu_req),
    .cur_flags(core_flags[3:0]),
    .next_flags(alu_next),
    .update(alu_update)
  );

  always_comb begin
    next_core = core_flags;
    // Data writes only touch the arithmetic flags
    if (wr_flags) begin
      next_core[3:0] = reg_wdata[3:0];
    end
    if (alu_update) begin
      next_core[3:0] = alu_next;
    end
    if (core_evt.halt_instr) begin
      next_core[cif_pkg::FLG_PDOWN] = 1'b1;
      next_core[cif_pkg::FLG_WDTO] = 1'b0;
    end
    if (core_evt.watchdog_clear_instr) begin
      next_core[cif_pkg::FLG_PDOWN] = 1'b0;
      next_core[cif_pkg::FLG_WDTO] = 1'b0;
    end
    if (core_evt.watchdog_timeout) begin
      next_core[cif_pkg::FLG_WDTO] = 1'b1;
    end
    next_core[7:6] = 2'b00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path and acknowledge sequencing
  assign next_rdata = !reg_rd ? 8'h00 :
                      (reg_addr == cif_pkg::ADDR_CORE_FLAGS) ? core_flags :
                      (reg_addr == cif_pkg::ADDR_IRQ_CTRL) ? irq_control_reg : 8'h00;

  always_comb begin
    case (state)
      cif_pkg::CIF_ST_IDLE: next_state = do_ack ? cif_pkg::CIF_ST_ACK : cif_pkg::CIF_ST_IDLE;
      // Ack then Hold forbid a second acknowledge for the two cycles after the first, with no wait on the core
      cif_pkg::CIF_ST_ACK: next_state = cif_pkg::CIF_ST_HOLD;
      cif_pkg::CIF_ST_HOLD: next_state = cif_pkg::CIF_ST_IDLE;
      default: next_state = cif_pkg::CIF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_pin_q <= 1'b1;
      irq_control_reg <= cif_pkg::IRQ_CTRL_RST;
      core_flags <= cif_pkg::CORE_FLAGS_RST;
      state <= cif_pkg::CIF_ST_IDLE;
    end else begin
      ext_pin_q <= ext_irq_n;
      irq_control_reg <= next_ctrl;
      core_flags <= next_core;
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'b0;
      push_pc <= 1'b0;
      irq_vector <= 11'h000;
      reg_rdata <= 8'h00;
      wake_req <= 1'b0;
    end else begin
      irq_ack <= do_ack;
      push_pc <= do_ack;
      if (do_ack) begin
        irq_vector <= next_vector;
      end
      reg_rdata <= next_rdata;
      // Wake only on fresh events while powered down
      wake_req <= core_flags[cif_pkg::FLG_PDOWN] && (|src_event);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_ext_sets_flag: assert property (@(posedge clk) disable iff (rst)
    ext_fall |=> ext_irq_pending)
    else $error("external falling edge did not set pending");

  chk_ack_on_phase: assert property (@(posedge clk) disable iff (rst)
    irq_ack |-> $past(phase_two_pulse))
    else $error("acknowledge without phase-two pulse");

  chk_stack_full_block: assert property (@(posedge clk) disable iff (rst)
    irq_ack |-> !$past(core_evt.stack_full))
    else $error("acknowledge while stack full");

  chk_ack_clears_global: assert property (@(posedge clk) disable iff (rst)
    irq_ack && !$past(core_evt.return_and_enable) |-> !global_irq_enable)
    else $error("global enable not cleared by acknowledge");

  chk_ext_priority: assert property (@(posedge clk) disable iff (rst)
    do_ack && ext_ready |=> irq_vector == cif_pkg::VEC_EXT)
    else $error("external not served first");

  chk_tmr_vector: assert property (@(posedge clk) disable iff (rst)
    take_tmr |=> irq_vector == cif_pkg::VEC_TMR
    && (!timer_irq_pending || $past(timer_overflow)))
    else $error("timer vector or clear wrong");

  chk_conv_vector: assert property (@(posedge clk) disable iff (rst)
    take_conv |=> irq_vector == cif_pkg::VEC_CONV
    && (!conv_irq_pending || $past(conv_done)))
    else $error("converter vector or clear wrong");

  chk_enable_gate: assert property (@(posedge clk) disable iff (rst)
    irq_ack |-> $past(global_irq_enable))
    else $error("acknowledge with global enable low");

  chk_return_and_enable_sets_global: assert property (@(posedge clk) disable iff (rst)
    core_evt.return_and_enable && !do_ack |=> global_irq_enable)
    else $error("return-and-enable did not set global enable");

  chk_flag_write_guard: assert property (@(posedge clk) disable iff (rst)
    wr_flags && !core_evt.halt_instr && !core_evt.watchdog_clear_instr
    && !core_evt.watchdog_timeout |=> $stable(core_flags[5:4]))
    else $error("data write changed power or time-out flag");

  chk_halt_flags: assert property (@(posedge clk) disable iff (rst)
    core_evt.halt_instr && !core_evt.watchdog_clear_instr && !core_evt.watchdog_timeout
    |=> core_flags[5:4] == 2'b01)
    else $error("halt flags wrong");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    irq_control_reg[7] == 1'b0 && core_flags[7:6] == 2'b00)
    else $error("reserved bits not zero");

  chk_ext_vector: assert property (@(posedge clk) disable iff (rst)
    take_ext |=> irq_vector == cif_pkg::VEC_EXT && !global_irq_enable
    && (!ext_irq_pending || $past(ext_fall)))
    else $error("external vector or clear wrong");

  chk_tmr_sets_flag: assert property (@(posedge clk) disable iff (rst)
    timer_overflow |=> timer_irq_pending)
    else $error("timer overflow did not set pending");

  chk_conv_sets_flag: assert property (@(posedge clk) disable iff (rst)
    conv_done |=> conv_irq_pending)
    else $error("conversion end did not set pending");

  chk_pending_holds: assert property (@(posedge clk) disable iff (rst)
    ext_irq_pending && !take_ext && !wr_ctrl |=> ext_irq_pending)
    else $error("external pending lost without acknowledge or write");

  chk_push_with_ack: assert property (@(posedge clk) disable iff (rst)
    push_pc == irq_ack)
    else $error("push and acknowledge differ");

  chk_ack_spacing: assert property (@(posedge clk) disable iff (rst)
    irq_ack |=> !irq_ack ##1 !irq_ack)
    else $error("acknowledge repeated too soon");

  chk_timeout_sets: assert property (@(posedge clk) disable iff (rst)
    core_evt.watchdog_timeout |=> core_flags[cif_pkg::FLG_WDTO])
    else $error("time-out did not set flag");

  chk_clear_instr: assert property (@(posedge clk) disable iff (rst)
    core_evt.watchdog_clear_instr && !core_evt.watchdog_timeout
    |=> core_flags[5:4] == 2'b00)
    else $error("watchdog clear did not clear flags");

  chk_wake_event: assert property (@(posedge clk) disable iff (rst)
    core_flags[cif_pkg::FLG_PDOWN] && (|src_event) |=> wake_req)
    else $error("event in power-down did not wake");

  chk_wake_only_pd: assert property (@(posedge clk) disable iff (rst)
    wake_req |-> $past(core_flags[cif_pkg::FLG_PDOWN]))
    else $error("wake while not powered down");

  chk_logic_zero: assert property (@(posedge clk) disable iff (rst)
    alu_req.op == cif_pkg::CIF_ALU_LOGIC
    |=> core_flags[cif_pkg::FLG_ZERO] == ($past(alu_req.result) == 8'h00))
    else $error("logic result zero flag wrong");

  chk_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == cif_pkg::ADDR_IRQ_CTRL |=> reg_rdata == $past(irq_control_reg))
    else $error("control register read back wrong");

  cov_ext_ack: cover property (@(posedge clk) disable iff (rst) take_ext);
  cov_blocked: cover property (@(posedge clk) disable iff (rst)
    phase_two_pulse && any_ready && core_evt.stack_full);
  cov_two_pending: cover property (@(posedge clk) disable iff (rst)
    do_ack && ext_ready && tmr_ready);
  cov_wake: cover property (@(posedge clk) disable iff (rst) wake_req);

endmodule
`default_nettype wire

// [rtl/cif_pkg.sv]
// Purpose: Shared constants and types for the core interrupt and status flag block
// Assumes: Data bus is 8 bits, program counter vectors are 11 bits
// Notes: Every address, bit position and vector lives here
package cif_pkg;

  localparam logic [6:0] ADDR_CORE_FLAGS = 7'h0A;
  localparam logic [6:0] ADDR_IRQ_CTRL = 7'h0B;

  // Core flag bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_PDOWN = 4;
  localparam int FLG_WDTO = 5;

  // Interrupt control bit positions
  localparam int IC_GLOBAL_EN = 0;
  localparam int IC_EXT_EN = 1;
  localparam int IC_TMR_EN = 2;
  localparam int IC_CONV_EN = 3;
  localparam int IC_EXT_PEND = 4;
  localparam int IC_TMR_PEND = 5;
  localparam int IC_CONV_PEND = 6;

  localparam logic [7:0] CORE_FLAGS_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] CORE_FLAGS_WMASK = 8'h0F;
  localparam logic [7:0] IRQ_CTRL_WMASK = 8'h7F;

  localparam logic [10:0] VEC_EXT = 11'h004;
  localparam logic [10:0] VEC_TMR = 11'h008;
  localparam logic [10:0] VEC_CONV = 11'h00C;

  typedef enum logic [2:0] {
    CIF_ALU_NONE = 3'h0,
    CIF_ALU_ADD = 3'h1,
    CIF_ALU_SUB = 3'h2,
    CIF_ALU_LOGIC = 3'h3,
    CIF_ALU_ROT = 3'h4
  } cif_alu_op_e;

  // Flag update request from the ALU
  typedef struct packed {
    cif_alu_op_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] result;
    logic carry_in;
    logic rot_carry;
  } cif_alu_req_s;

  // Core control events sampled by the block
  typedef struct packed {
    logic halt_instr;
    logic watchdog_clear_instr;
    logic watchdog_timeout;
    logic return_and_enable;
    logic plain_return;
    logic stack_full;
  } cif_core_evt_s;

  typedef enum logic [2:0] {
    CIF_ST_IDLE = 3'b001,
    CIF_ST_ACK = 3'b010,
    CIF_ST_HOLD = 3'b100
  } cif_state_e;

endpackage

// [rtl/cif_alu_flags.sv]
// Purpose: Derives carry, half carry, zero and overflow from an ALU operation
// Assumes: Subtraction is a - b - not(carry_in), result supplied by the core
// Notes: Purely combinational; the caller registers the flags
`timescale 1ns/1ps
`default_nettype none
module cif_alu_flags (
  input wire cif_pkg::cif_alu_req_s req,
  input wire logic [3:0] cur_flags,
  output logic [3:0] next_flags,
  output logic update
);
  logic [8:0] add_sum;
  logic [4:0] add_low;
  logic [7:0] add_mid;
  logic [8:0] sub_diff;
  logic [4:0] sub_low;
  logic [7:0] sub_mid;
  logic is_add;
  logic is_sub;
  logic carry7_in;
  logic carry_out;
  logic half_c;

  assign add_sum = {1'b0, req.a} + {1'b0, req.b} + {8'h00, req.carry_in};
  assign add_low = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, req.carry_in};
  assign add_mid = {1'b0, req.a[6:0]} + {1'b0, req.b[6:0]} + {7'h00, req.carry_in};
  // Subtract as a + ~b + carry_in so carry means no borrow
  assign sub_diff = {1'b0, req.a} + {1'b0, ~req.b} + {8'h00, req.carry_in};
  assign sub_low = {1'b0, req.a[3:0]} + {1'b0, ~req.b[3:0]} + {4'h0, req.carry_in};
  assign sub_mid = {1'b0, req.a[6:0]} + {1'b0, ~req.b[6:0]} + {7'h00, req.carry_in};
  assign is_add = (req.op == cif_pkg::CIF_ALU_ADD);
  assign is_sub = (req.op == cif_pkg::CIF_ALU_SUB);
  assign carry_out = is_add ? add_sum[8] : sub_diff[8];
  assign half_c = is_add ? add_low[4] : sub_low[4];
  assign carry7_in = is_add ? add_mid[7] : sub_mid[7];
  assign update = (req.op != cif_pkg::CIF_ALU_NONE);

  always_comb begin
    next_flags = cur_flags;
    case (req.op)
      cif_pkg::CIF_ALU_ADD, cif_pkg::CIF_ALU_SUB: begin
        next_flags[cif_pkg::FLG_CARRY] = carry_out;
        next_flags[cif_pkg::FLG_HALF] = half_c;
        next_flags[cif_pkg::FLG_ZERO] = (req.result == 8'h00);
        next_flags[cif_pkg::FLG_OVF] = carry7_in ^ carry_out;
      end
      cif_pkg::CIF_ALU_LOGIC: begin
        next_flags[cif_pkg::FLG_ZERO] = (req.result == 8'h00);
      end
      cif_pkg::CIF_ALU_ROT: begin
        next_flags[cif_pkg::FLG_CARRY] = req.rot_carry;
      end
      default: begin
        next_flags = cur_flags;
      end
    endcase
  end
  // Unused sum bits are intentional; only carries matter here
  logic unused_bits;
  assign unused_bits = ^{add_sum[7:0], sub_diff[7:0], add_low[3:0], sub_low[3:0],
                         add_mid[6:0], sub_mid[6:0], is_sub};
endmodule
`default_nettype wire

// [verification/cif_core_model.sv]
// Purpose: Behavioural core model: phase-two pulse and return stack depth
// Assumes: Six stack levels, phase-two pulse every fourth clock
// Notes: Stack overflow by a call keeps depth at six, as the real stack does
`timescale 1ns/1ps
`default_nettype none
module cif_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic push_pc,
  input wire logic call,
  input wire logic pop,
  output logic phase_two_pulse,
  output logic stack_full
);
  logic [1:0] phase;
  logic [2:0] depth;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      depth <= 3'h0;
    end else begin
      phase <= phase + 2'h1;
      if ((push_pc || call) && depth != 3'h6) begin
        depth <= depth + 3'h1;
      end else if (pop && !push_pc && depth != 3'h0) begin
        depth <= depth - 3'h1;
      end
    end
  end
  assign phase_two_pulse = (phase == 2'h3);
  assign stack_full = (depth == 3'h6);
endmodule
`default_nettype wire

// [verification/cif_top_tb.sv]
// Purpose: Self-checking bench for the interrupt and status flag block
// Assumes: Inputs move 2 ns after the rising edge
// Notes: Random ALU operands from a fixed seed, corner cases first
`timescale 1ns/1ps
`default_nettype none
module cif_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext_irq_n = 1'b1;
  logic timer_overflow = 1'b0;
  logic conv_done = 1'b0;
  logic halt = 1'b0, wclr = 1'b0, wto = 1'b0, reten = 1'b0, pret = 1'b0, call = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  cif_pkg::cif_alu_req_s alu_req = '0;
  cif_pkg::cif_core_evt_s core_evt;
  wire logic phase_two_pulse, stack_full, irq_ack, push_pc, wake_req;
  wire logic [7:0] reg_rdata, irq_control_reg, core_flags;
  wire logic [10:0] irq_vector;
  int failures = 0, total_checks = 0, seed = 8, i;
  logic [7:0] a, b;
  logic cin, sub;

  assign core_evt = {halt, wclr, wto, reten, pret, stack_full};
  always #12.5 clk = ~clk;

  cif_top u_cif_top (.clk(clk), .rst(rst), .ext_irq_n(ext_irq_n),
    .timer_overflow(timer_overflow), .conv_done(conv_done),
    .phase_two_pulse(phase_two_pulse), .core_evt(core_evt), .alu_req(alu_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_control_reg(irq_control_reg), .core_flags(core_flags),
    .irq_ack(irq_ack), .irq_vector(irq_vector), .push_pc(push_pc), .wake_req(wake_req));
  cif_core_model u_cif_core_model (.clk(clk), .rst(rst), .push_pc(push_pc), .call(call),
    .pop(reten | pret), .phase_two_pulse(phase_two_pulse), .stack_full(stack_full));

  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #2;
  endtask
  task chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task wr(input logic [6:0] ad, input logic [7:0] d);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
  endtask
  task rd(input logic [6:0] ad, input logic [7:0] exp, input string msg);
    reg_addr = ad;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    chk({3'h0, reg_rdata}, {3'h0, exp}, msg);
    // Idle edge so a following read never re-raises the strobe at once
    tick;
  endtask
  // Bounded wait; phase pulses come every 4 clocks, so 6 covers one interval
  task wait_ack(input int bound, input logic [10:0] vec);
    int n;
    n = 0;
    while (irq_ack !== 1'b1 && n < bound) begin
      tick;
      n++;
    end
    if (irq_ack !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t acknowledge missing", $time);
      stop_test;
    end else begin
      chk(irq_vector, vec, "vector");
      chk({10'h0, push_pc}, 11'h001, "push with ack");
    end
  endtask
  task no_ack(input int n);
    repeat (n) begin
      tick;
      chk({10'h0, irq_ack}, 11'h000, "unexpected ack");
    end
  endtask
  task src_evt(input int k);
    if (k == 0) ext_irq_n = 1'b0;
    if (k == 1) timer_overflow = 1'b1;
    if (k == 2) conv_done = 1'b1;
    tick;
    ext_irq_n = 1'b1;
    timer_overflow = 1'b0;
    conv_done = 1'b0;
  endtask
  // Flags as {ovf, zero, half, carry}; subtraction adds the inverted operand
  function automatic logic [3:0] exp_flags(input logic [7:0] x, y, input logic c, s);
    logic [7:0] yy, l7;
    logic [8:0] t;
    logic [4:0] lo;
    yy = s ? ~y : y;
    t = {1'b0, x} + {1'b0, yy} + {8'h00, c};
    lo = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, c};
    l7 = {1'b0, x[6:0]} + {1'b0, yy[6:0]} + {7'h00, c};
    return {l7[7] ^ t[8], t[7:0] == 8'h00, lo[4], t[8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #2;
    rst = 1'b0;
    rd(cif_pkg::ADDR_CORE_FLAGS, 8'h00, "flags reset");
    rd(cif_pkg::ADDR_IRQ_CTRL, 8'h00, "control reset");
    rd(7'h0C, 8'h00, "unmapped read");
    wr(cif_pkg::ADDR_CORE_FLAGS, 8'hFF);
    rd(cif_pkg::ADDR_CORE_FLAGS, 8'h0F, "flags write mask");
    halt = 1'b1;
    tick;
    halt = 1'b0;
    chk({9'h0, core_flags[5:4]}, 11'h001, "halt sets pd");
    wr(cif_pkg::ADDR_CORE_FLAGS, 8'h00);
    chk({9'h0, core_flags[5:4]}, 11'h001, "write kept pd");
    for (i = 0; i < 3; i++) begin
      src_evt(i);
      chk({10'h0, wake_req}, 11'h001, "wake");
      tick;
      chk({10'h0, wake_req}, 11'h000, "wake pulse");
    end
    rd(cif_pkg::ADDR_IRQ_CTRL, 8'h70, "pending while masked");
    wto = 1'b1;
    tick;
    wto = 1'b0;
    chk({9'h0, core_flags[5:4]}, 11'h003, "timeout sets to");
    halt = 1'b1;
    tick;
    halt = 1'b0;
    chk({9'h0, core_flags[5:4]}, 11'h001, "halt clears to");
    wto = 1'b1;
    tick;
    wto = 1'b0;
    wclr = 1'b1;
    tick;
    wclr = 1'b0;
    chk({9'h0, core_flags[5:4]}, 11'h000, "clear instr");
    for (i = 0; i < 24; i++) begin
      a = (i == 0) ? 8'h7F : 8'($random(seed));
      b = (i < 2) ? {7'h00, i == 0} : 8'($random(seed));
      sub = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($random(seed));
      cin = sub & ((i == 1) | 1'($random(seed)));
      if (i == 1) a = 8'h01;
      alu_req.op = sub ? cif_pkg::CIF_ALU_SUB : cif_pkg::CIF_ALU_ADD;
      alu_req.a = a;
      alu_req.b = b;
      alu_req.carry_in = cin;
      alu_req.result = a + (sub ? ~b : b) + {7'h00, cin};
      tick;
      chk({7'h0, core_flags[3:0]}, {7'h0, exp_flags(a, b, cin, sub)}, "alu flags");
    end
    alu_req.op = cif_pkg::CIF_ALU_LOGIC;
    alu_req.result = 8'h01;
    tick;
    chk({10'h0, core_flags[2]}, 11'h000, "logic nonzero");
    alu_req.result = 8'h00;
    tick;
    chk({10'h0, core_flags[2]}, 11'h001, "logic zero");
    alu_req.op = cif_pkg::CIF_ALU_ROT;
    alu_req.rot_carry = 1'b1;
    tick;
    alu_req.op = cif_pkg::CIF_ALU_NONE;
    chk({10'h0, core_flags[0]}, 11'h001, "rotate carry");
    no_ack(6);
    wr(cif_pkg::ADDR_IRQ_CTRL, 8'h7F);
    wait_ack(6, cif_pkg::VEC_EXT);
    chk({3'h0, irq_control_reg}, 11'h06E, "ext cleared");
    reten = 1'b1;
    tick;
    reten = 1'b0;
    wait_ack(6, cif_pkg::VEC_TMR);
    chk({3'h0, irq_control_reg}, 11'h04E, "timer cleared");
    pret = 1'b1;
    tick;
    pret = 1'b0;
    no_ack(8);
    reten = 1'b1;
    tick;
    reten = 1'b0;
    wait_ack(6, cif_pkg::VEC_CONV);
    chk({3'h0, irq_control_reg}, 11'h00E, "conv cleared");
    wr(cif_pkg::ADDR_IRQ_CTRL, 8'h71);
    no_ack(8);
    wr(cif_pkg::ADDR_IRQ_CTRL, 8'h73);
    wait_ack(6, cif_pkg::VEC_EXT);
    call = 1'b1;
    repeat (6) tick;
    call = 1'b0;
    wr(cif_pkg::ADDR_IRQ_CTRL, 8'h05);
    src_evt(1);
    chk({10'h0, wake_req}, 11'h000, "no wake when running");
    no_ack(8);
    chk({3'h0, irq_control_reg}, 11'h025, "held while full");
    reten = 1'b1;
    tick;
    reten = 1'b0;
    wait_ack(8, cif_pkg::VEC_TMR);
    stop_test;
  end
endmodule
`default_nettype wire
